/* File: rtl/scan_cfg_pkg.sv */
// shared constants and types of the local scan port configuration block
package scan_cfg_pkg;

  // ----------------------------------------------------------------------
  // variant and sizes
  // ----------------------------------------------------------------------
  localparam int        NUM_PORTS   = 8;
  localparam int        MR_W        = 8;
  localparam int        FIFO_DEPTH  = 32;
  // set for the synthesizable eight port variant, clear for the three port one
  localparam logic      HDL_VARIANT = 1'b1;

  // ----------------------------------------------------------------------
  // mode register layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIMARY_RESET   = 8'h01;
  localparam logic [7:0] EXTENDED_RESET  = 8'h00;
  localparam int         SEL0_BIT        = 0;
  localparam int         SEL1_BIT        = 1;
  localparam int         SEL2_BIT        = 2;
  localparam int         CLK_DIS_BIT     = 3;
  localparam int         LOOPBACK_BIT    = 4;
  localparam int         SEL3_BIT        = 5;
  localparam int         SEL4_BIT        = 6;
  localparam int         STATUS_BIT      = 7;
  localparam int         EXT_SEL5_BIT    = 0;
  localparam int         EXT_SEL6_BIT    = 1;
  localparam int         EXT_SEL7_BIT    = 2;
  // writable bits; status is hardware owned, reserved bits stay zero
  localparam logic [7:0] PRIMARY_WR_MASK = HDL_VARIANT ? 8'h7f : 8'h1f;
  localparam logic [7:0] EXT_WR_MASK     = HDL_VARIANT ? 8'h07 : 8'h00;

  // ----------------------------------------------------------------------
  // parking
  // ----------------------------------------------------------------------
  localparam logic [1:0] KIND_RESET    = 2'h0;
  localparam logic [1:0] KIND_IDLE     = 2'h1;
  localparam logic [1:0] KIND_PAUSE_DR = 2'h2;
  localparam logic [1:0] KIND_PAUSE_IR = 2'h3;
  localparam int         TLR_CNT_W     = 10;
  localparam logic [TLR_CNT_W-1:0] TLR_GATE_COUNT = 10'h200;

  typedef enum logic [4:0] {
    ST_UNPARKED             = 5'b00001,
    ST_PARKED_IN_RESET      = 5'b00010,
    ST_PARKED_IDLE          = 5'b00100,
    ST_PARKED_PAUSE_DR      = 5'b01000,
    ST_PARKED_PAUSE_IR      = 5'b10000
  } link_st_e;

  // snapshot of the configuration handed to the system side
  typedef struct packed {
    logic       unparked;
    logic [7:0] extended_port_config;
    logic [7:0] primary_port_config;
  } cfg_rec_s;

  localparam int CFG_REC_W = $bits(cfg_rec_s);

endpackage : scan_cfg_pkg

/* File: rtl/cfg_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cfg_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic  full;
  logic  empty;

  assign empty       = st.wr_ptr == st.rd_ptr;
  assign full        = (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]) && (st.wr_ptr[AW] != st.rd_ptr[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = st.mem[st.rd_ptr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid_i && !full) begin
      next_st.mem[st.wr_ptr[AW-1:0]] = in_data_i;
      next_st.wr_ptr                 = st.wr_ptr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (srst_i) begin
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

endmodule : cfg_fifo
`default_nettype wire

/* File: rtl/scan_port_config.sv */
// mode register logic and local scan port network of the multidrop bridge
`timescale 1ns/1ps
`default_nettype none

module scan_port_config (
  input  wire logic                           CLK_I,
  input  wire logic                           SRST_I,
  input  wire logic                           TCK_I,
  input  wire logic                           TLR_I,
  input  wire logic                           SEL_PRIMARY_I,
  input  wire logic                           SEL_EXT_I,
  input  wire logic                           CAPTURE_DR_I,
  input  wire logic                           SHIFT_DR_I,
  input  wire logic                           UPDATE_DR_I,
  input  wire logic                           UNPARK_I,
  input  wire logic                           PARK_I,
  input  wire logic [1:0]                     PARK_KIND_I,
  input  wire logic                           CNTR_ON_I,
  input  wire logic                           CNTR_ZERO_I,
  input  wire logic                           CNTR_LOAD_I,
  input  wire logic                           TDI_B_I,
  input  wire logic                           DR_TDO_I,
  input  wire logic [scan_cfg_pkg::NUM_PORTS-1:0] LP_TDO_I,
  output logic                                TDO_B_O,
  output logic                                TDO_B_OE_O,
  output logic [scan_cfg_pkg::NUM_PORTS-1:0]  LP_TDI_O,
  output logic [scan_cfg_pkg::NUM_PORTS-1:0]  LP_TCK_EN_O,
  output logic                                CFG_VALID_O,
  input  wire logic                           CFG_READY_I,
  output scan_cfg_pkg::cfg_rec_s              CFG_DATA_O
);
  import scan_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // state of the link (TCK) domain
  // ----------------------------------------------------------------------
  typedef struct packed {
    link_st_e               state;
    logic [MR_W-1:0]        primary_port_config;
    logic [MR_W-1:0]        extended_port_config;
    logic [MR_W-1:0]        shreg;
    logic [NUM_PORTS-1:0]   active;
    logic [NUM_PORTS-1:0]   pad;
    logic [TLR_CNT_W-1:0]   tlr_cnt;
    logic [NUM_PORTS-1:0]   tck_en;
    logic                   req;
    cfg_rec_s               snap;
    logic                   ack_meta;
    logic                   ack_sync;
  } link_s;

  typedef struct packed {
    logic                   tdo;
    logic                   tdo_oe;
    logic [NUM_PORTS-1:0]   lp_tdi;
  } link_out_s;

  typedef struct packed {
    logic                   req_meta;
    logic                   req_sync;
    logic                   ack;
    logic                   out_valid;
    cfg_rec_s               out_data;
  } sys_s;

  link_s                  link;
  link_s                  next_link;
  link_out_s              lout;
  link_out_s              next_lout;
  sys_s                   sys;
  sys_s                   next_sys;

  logic [NUM_PORTS-1:0]   sel_vec;
  logic [NUM_PORTS-1:0]   in_chain;
  logic [NUM_PORTS:0]     src;
  logic                   own_tdo;
  logic                   parked_gate;
  cfg_rec_s               cur_cfg;
  logic                   push_valid;
  logic                   push_ready;
  logic                   pop_valid;
  logic                   pop_ready;
  cfg_rec_s               pop_data;

  // ----------------------------------------------------------------------
  // port select vector and scan path
  // ----------------------------------------------------------------------
  assign sel_vec = {link.extended_port_config[EXT_SEL7_BIT],
                    link.extended_port_config[EXT_SEL6_BIT],
                    link.extended_port_config[EXT_SEL5_BIT],
                    link.primary_port_config[SEL4_BIT],
                    link.primary_port_config[SEL3_BIT],
                    link.primary_port_config[SEL2_BIT],
                    link.primary_port_config[SEL1_BIT],
                    link.primary_port_config[SEL0_BIT]};

  // loopback applies at once; the port set itself only moves at unpark
  assign in_chain = (link.state == ST_UNPARKED && !link.primary_port_config[LOOPBACK_BIT])
                    ? link.active : '0;

  assign own_tdo = (SEL_PRIMARY_I || SEL_EXT_I) ? link.shreg[0] : DR_TDO_I;
  assign src[0]  = own_tdo;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_chain
      // a port in the chain is followed by its pad bit, lower index first
      assign src[g+1] = in_chain[g] ? link.pad[g] : src[g];
    end
  endgenerate

  assign parked_gate = link.primary_port_config[CLK_DIS_BIT] || (CNTR_ON_I && CNTR_ZERO_I);

  assign cur_cfg = '{unparked:             link.state == ST_UNPARKED,
                     extended_port_config: link.extended_port_config,
                     primary_port_config:  link.primary_port_config};

  // ----------------------------------------------------------------------
  // link domain, rising edge
  // ----------------------------------------------------------------------
  always_comb begin
    next_link          = link;
    next_link.ack_meta = sys.ack;
    next_link.ack_sync = link.ack_meta;

    // status bit: load clears, terminal count sets, set wins
    if (CNTR_LOAD_I) begin
      next_link.primary_port_config[STATUS_BIT] = 1'b0;
    end
    if (CNTR_ON_I && CNTR_ZERO_I) begin
      next_link.primary_port_config[STATUS_BIT] = 1'b1;
    end

    if (CAPTURE_DR_I) begin
      next_link.shreg = SEL_EXT_I ? link.extended_port_config : link.primary_port_config;
    end else if (SHIFT_DR_I) begin
      next_link.shreg = {TDI_B_I, link.shreg[MR_W-1:1]};
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (in_chain[k]) begin
          next_link.pad[k] = LP_TDO_I[k];
        end
      end
    end else if (UPDATE_DR_I && SEL_PRIMARY_I) begin
      next_link.primary_port_config = (link.shreg & PRIMARY_WR_MASK) |
                                      (next_link.primary_port_config & ~PRIMARY_WR_MASK);
    end else if (UPDATE_DR_I && SEL_EXT_I) begin
      next_link.extended_port_config = link.shreg & EXT_WR_MASK;
    end

    if (UNPARK_I) begin
      next_link.state  = ST_UNPARKED;
      next_link.active = sel_vec;
    end else if (PARK_I) begin
      unique case (PARK_KIND_I)
        KIND_RESET:    next_link.state = ST_PARKED_IN_RESET;
        KIND_IDLE:     next_link.state = ST_PARKED_IDLE;
        KIND_PAUSE_DR: next_link.state = ST_PARKED_PAUSE_DR;
        KIND_PAUSE_IR: next_link.state = ST_PARKED_PAUSE_IR;
      endcase
    end

    if (link.state == ST_PARKED_IN_RESET) begin
      if (link.tlr_cnt != TLR_GATE_COUNT) begin
        next_link.tlr_cnt = link.tlr_cnt + 1'b1;
      end
    end else begin
      next_link.tlr_cnt = '0;
    end

    // enables are registered, so a gate change lands one TCK later
    unique case (link.state)
      ST_UNPARKED: begin
        next_link.tck_en = '1;
      end
      ST_PARKED_IN_RESET: begin
        next_link.tck_en = {NUM_PORTS{next_link.tlr_cnt != TLR_GATE_COUNT}};
      end
      ST_PARKED_IDLE, ST_PARKED_PAUSE_DR, ST_PARKED_PAUSE_IR: begin
        next_link.tck_en = {NUM_PORTS{!parked_gate}};
      end
      default: begin
        next_link.tck_en = '0;
      end
    endcase

    // hand a fresh snapshot over only when the last one was taken
    if ((link.req == link.ack_sync) && (cur_cfg != link.snap)) begin
      next_link.snap = cur_cfg;
      next_link.req  = !link.req;
    end

    if (TLR_I) begin
      next_link.state                = ST_PARKED_IN_RESET;
      next_link.primary_port_config  = PRIMARY_RESET;
      next_link.extended_port_config = EXTENDED_RESET;
      next_link.shreg                = '0;
      next_link.active               = '0;
      next_link.pad                  = '0;
      next_link.tlr_cnt              = '0;
      next_link.tck_en               = '1;
      next_link.req                  = 1'b0;
      next_link.snap                 = '{unparked:             1'b0,
                                         extended_port_config: EXTENDED_RESET,
                                         primary_port_config:  PRIMARY_RESET};
      next_link.ack_meta             = 1'b0;
      next_link.ack_sync             = 1'b0;
    end
  end

  always_ff @(posedge TCK_I) begin
    link <= next_link;
  end

  // ----------------------------------------------------------------------
  // link domain, falling edge outputs; the clock enables come from the rising edge
  // ----------------------------------------------------------------------
  always_comb begin
    next_lout        = lout;
    next_lout.tdo    = src[NUM_PORTS];
    next_lout.tdo_oe = SHIFT_DR_I;
    next_lout.lp_tdi = src[NUM_PORTS-1:0];
    if (TLR_I) begin
      next_lout = '0;
    end
  end

  always_ff @(negedge TCK_I) begin
    lout <= next_lout;
  end

  assign TDO_B_O     = lout.tdo;
  assign TDO_B_OE_O  = lout.tdo_oe;
  assign LP_TDI_O    = lout.lp_tdi;
  assign LP_TCK_EN_O = link.tck_en;

  // ----------------------------------------------------------------------
  // system domain: handshake receive and fifo
  // ----------------------------------------------------------------------
  // snap is held still by the link side until the ack comes back
  assign push_valid = sys.req_sync != sys.ack;
  assign pop_ready  = !sys.out_valid || CFG_READY_I;

  cfg_fifo #(
    .WIDTH       (CFG_REC_W),
    .DEPTH       (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (link.snap),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  always_comb begin
    next_sys          = sys;
    next_sys.req_meta = link.req;
    next_sys.req_sync = sys.req_meta;
    // a full fifo withholds the ack, which stalls further snapshots
    if (push_valid && push_ready) begin
      next_sys.ack = sys.req_sync;
    end
    if (pop_ready) begin
      next_sys.out_valid = pop_valid;
      if (pop_valid) begin
        next_sys.out_data = pop_data;
      end
    end
    if (SRST_I) begin
      next_sys = '0;
    end
  end

  always_ff @(posedge CLK_I) begin
    sys <= next_sys;
  end

  assign CFG_VALID_O = sys.out_valid;
  assign CFG_DATA_O  = sys.out_data;

endmodule : scan_port_config
`default_nettype wire

/* File: sim/scan_port_config_properties.sv */
// concurrent checks on the ports of the scan port configuration block
`timescale 1ns/1ps
`default_nettype none
module scan_port_config_properties (
  input wire logic                   CLK_I,
  input wire logic                   SRST_I,
  input wire logic                   TCK_I,
  input wire logic                   TLR_I,
  input wire logic                   UNPARK_I,
  input wire logic                   PARK_I,
  input wire logic [1:0]             PARK_KIND_I,
  input wire logic                   CNTR_ON_I,
  input wire logic                   CNTR_ZERO_I,
  input wire logic [7:0]             LP_TCK_EN_O,
  input wire logic                   CFG_VALID_O,
  input wire logic                   CFG_READY_I,
  input wire scan_cfg_pkg::cfg_rec_s CFG_DATA_O
);
  import scan_cfg_pkg::*;
  // ------------------------------------------------------------
  // link side helpers
  // ------------------------------------------------------------
  // counts edges spent parked in reset since release; parks and unparks stop it
  logic [10:0] tlr_cnt;
  logic        unp;
  logic        idle_park;
  always_ff @(posedge TCK_I) begin
    if (TLR_I) begin
      tlr_cnt   <= 11'h000;
      unp       <= 1'b0;
      idle_park <= 1'b0;
    end else if (UNPARK_I || PARK_I) begin
      tlr_cnt   <= 11'h7ff;
      unp       <= !PARK_I;
      idle_park <= PARK_I && PARK_KIND_I == KIND_IDLE;
    end else if (tlr_cnt != 11'h7ff) begin
      tlr_cnt <= tlr_cnt + 11'h001;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_tlr_clk_on: assert property (@(posedge TCK_I) disable iff (TLR_I)
    $fell(TLR_I) |-> LP_TCK_EN_O == 8'hff) else $error("clocks stopped at reset exit");
  a_tlr_gate_late: assert property (@(posedge TCK_I) disable iff (TLR_I)
    tlr_cnt == 11'h1ff |-> LP_TCK_EN_O == 8'hff) else $error("clocks stopped early");
  a_tlr_gate_stop: assert property (@(posedge TCK_I) disable iff (TLR_I)
    tlr_cnt == 11'h200 |-> LP_TCK_EN_O == 8'h00) else $error("clocks not stopped");
  a_unpark_run: assert property (@(posedge TCK_I) disable iff (TLR_I)
    unp && $past(unp) |-> LP_TCK_EN_O == 8'hff) else $error("unparked clocks stopped");
  a_en_uniform: assert property (@(posedge TCK_I) disable iff (TLR_I)
    LP_TCK_EN_O == 8'h00 || LP_TCK_EN_O == 8'hff) else $error("clock enables differ");
  a_counter_gate: assert property (@(posedge TCK_I) disable iff (TLR_I)
    (idle_park && CNTR_ON_I && CNTR_ZERO_I)[*2] |-> LP_TCK_EN_O == 8'h00)
    else $error("clocks run at terminal count");
  a_cfg_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CFG_VALID_O && !CFG_READY_I |=> CFG_VALID_O && $stable(CFG_DATA_O))
    else $error("record dropped before taken");
  a_srst_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
    $fell(SRST_I) |-> !CFG_VALID_O) else $error("record valid after reset");
endmodule : scan_port_config_properties

bind scan_port_config scan_port_config_properties i_scan_port_config_properties (
  .CLK_I, .SRST_I, .TCK_I, .TLR_I, .UNPARK_I, .PARK_I, .PARK_KIND_I, .CNTR_ON_I,
  .CNTR_ZERO_I, .LP_TCK_EN_O, .CFG_VALID_O, .CFG_READY_I, .CFG_DATA_O
);
`default_nettype wire

/* File: sim/local_chain_model.sv */
// local scan chains: port k is a shift path of k+1 stages
`timescale 1ns/1ps
`default_nettype none
module local_chain_model (
  input  wire logic       tck_i,
  input  wire logic       shift_i,
  input  wire logic [7:0] tck_en_i,
  input  wire logic [7:0] tdi_i,
  output logic      [7:0] tdo_o
);
  logic [7:0] stage [8];
  initial tdo_o = 8'h00;
  always @(posedge tck_i) begin
    for (int k = 0; k < 8; k++) begin
      if (tck_en_i[k] && shift_i) begin
        stage[k]    <= {1'b0, stage[k][7:1]};
        stage[k][k] <= tdi_i[k];
      end
    end
  end
  // outside shifting or with its clock stopped the line toggles, so stale data never matches
  always @(negedge tck_i) begin
    for (int k = 0; k < 8; k++) begin
      tdo_o[k] <= (tck_en_i[k] && shift_i) ? stage[k][0] : !tdo_o[k];
    end
  end
endmodule : local_chain_model
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the scan port configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scan_cfg_pkg::*;
  logic        CLK_I = 1'b0, SRST_I = 1'b1, TCK_I = 1'b0, TLR_I = 1'b1;
  logic        SEL_PRIMARY_I = 1'b0, SEL_EXT_I = 1'b0, CAPTURE_DR_I = 1'b0, SHIFT_DR_I = 1'b0;
  logic        UPDATE_DR_I = 1'b0, UNPARK_I = 1'b0, PARK_I = 1'b0, CNTR_ON_I = 1'b0;
  logic        CNTR_ZERO_I = 1'b0, CNTR_LOAD_I = 1'b0, TDI_B_I = 1'b0, DR_TDO_I = 1'b0;
  logic        CFG_READY_I = 1'b0, TDO_B_O, TDO_B_OE_O, CFG_VALID_O;
  logic [1:0]  PARK_KIND_I = 2'h0;
  logic [7:0]  LP_TDO_I, LP_TDI_O, LP_TCK_EN_O;
  cfg_rec_s    CFG_DATA_O, last_rec;
  int          err_total = 0, n_tests = 0, n_rec = 0;
  logic [63:0] r;
  localparam logic [63:0] PAT = 64'h9c3a_5e71_d2b4_0f6e;

  always #12.5 CLK_I = ~CLK_I;
  always #24 TCK_I = ~TCK_I;

  scan_port_config i_scan_port_config (.CLK_I, .SRST_I, .TCK_I, .TLR_I, .SEL_PRIMARY_I,
    .SEL_EXT_I, .CAPTURE_DR_I, .SHIFT_DR_I, .UPDATE_DR_I, .UNPARK_I, .PARK_I, .PARK_KIND_I,
    .CNTR_ON_I, .CNTR_ZERO_I, .CNTR_LOAD_I, .TDI_B_I, .DR_TDO_I, .LP_TDO_I, .TDO_B_O,
    .TDO_B_OE_O, .LP_TDI_O, .LP_TCK_EN_O, .CFG_VALID_O, .CFG_READY_I, .CFG_DATA_O);
  local_chain_model i_local_chain_model (.tck_i(TCK_I), .shift_i(SHIFT_DR_I),
    .tck_en_i(LP_TCK_EN_O), .tdi_i(LP_TDI_O), .tdo_o(LP_TDO_I));

  always @(posedge CLK_I) begin
    if (CFG_VALID_O === 1'b1 && CFG_READY_I) begin
      last_rec <= CFG_DATA_O;
      n_rec    <= n_rec + 1;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // capture, n shifts lsb first, optional update; r collects what left on tdo
  task scan(input logic ext, input logic upd, input int n, input logic [63:0] w);
    SEL_PRIMARY_I <= !ext;
    SEL_EXT_I     <= ext;
    CAPTURE_DR_I  <= 1'b1;
    @(posedge TCK_I);
    CAPTURE_DR_I <= 1'b0;
    SHIFT_DR_I   <= 1'b1;
    for (int i = 0; i < n; i++) begin
      TDI_B_I <= w[i];
      @(posedge TCK_I);
      r[i] = TDO_B_O;
      chk({63'h0, TDO_B_OE_O}, 64'h1);
    end
    SHIFT_DR_I  <= 1'b0;
    UPDATE_DR_I <= upd;
    @(posedge TCK_I);
    UPDATE_DR_I   <= 1'b0;
    SEL_PRIMARY_I <= 1'b0;
    SEL_EXT_I     <= 1'b0;
    @(posedge TCK_I);
  endtask : scan
  task wr(input logic ext, input logic [7:0] w);
    scan(ext, 1'b1, 8, {56'h0, w});
  endtask : wr
  task rd(input logic ext, input logic [7:0] exp);
    scan(ext, 1'b0, 8, 64'h0);
    chk({56'h0, r[7:0]}, {56'h0, exp});
  endtask : rd
  // data must reappear delayed by the whole chain length
  task chain(input int len);
    scan(1'b0, 1'b0, 64, PAT);
    chk(r >> len, PAT & ((64'h1 << (64 - len)) - 64'h1));
  endtask : chain
  task park(input logic [1:0] kind, input logic go);
    PARK_KIND_I <= kind;
    PARK_I      <= go;
    UNPARK_I    <= !go;
    @(posedge TCK_I);
    PARK_I   <= 1'b0;
    UNPARK_I <= 1'b0;
    @(posedge TCK_I);
  endtask : park
  task en_is(input logic [7:0] exp);
    repeat (2) @(posedge TCK_I);
    @(negedge TCK_I);
    chk({56'h0, LP_TCK_EN_O}, {56'h0, exp});
    @(posedge TCK_I);
  endtask : en_is
  task end_sim;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
  end
  initial begin
    #1_000_000;
    err_total++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end
  initial begin
    repeat (2) @(posedge TCK_I);
    TLR_I <= 1'b0;
    @(posedge TCK_I);
    rd(1'b0, 8'h01);
    rd(1'b1, 8'h00);
    wr(1'b0, 8'hff);
    rd(1'b0, 8'h7f);
    wr(1'b1, 8'hff);
    rd(1'b1, 8'h07);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h05);
    repeat (520) @(posedge TCK_I);
    en_is(8'h00);
    park(KIND_IDLE, 1'b1);
    en_is(8'hff);
    chain(8);
    CNTR_ON_I <= 1'b1;
    repeat (2) @(posedge TCK_I);
    rd(1'b0, 8'h05);
    CNTR_ZERO_I <= 1'b1;
    en_is(8'h00);
    rd(1'b0, 8'h85);
    CNTR_ON_I   <= 1'b0;
    CNTR_ZERO_I <= 1'b0;
    rd(1'b0, 8'h85);
    CNTR_LOAD_I <= 1'b1;
    @(posedge TCK_I);
    CNTR_LOAD_I <= 1'b0;
    rd(1'b0, 8'h05);
    for (int k = 1; k < 4; k++) begin
      for (int b = 0; b < 2; b++) begin
        wr(1'b0, b ? 8'h0d : 8'h05);
        park(2'(k), 1'b1);
        en_is(b ? 8'h00 : 8'hff);
      end
    end
    park(KIND_IDLE, 1'b0);
    en_is(8'hff);
    chain(14);
    wr(1'b0, 8'h0f);
    chain(14);
    park(KIND_IDLE, 1'b0);
    chain(17);
    wr(1'b1, 8'h07);
    wr(1'b0, 8'h67);
    park(KIND_IDLE, 1'b0);
    chain(52);
    wr(1'b0, 8'h1f);
    chain(8);
    park(KIND_RESET, 1'b1);
    repeat (510) @(posedge TCK_I);
    @(negedge TCK_I);
    chk({56'h0, LP_TCK_EN_O}, 64'hff);
    @(posedge TCK_I);
    @(negedge TCK_I);
    chk({56'h0, LP_TCK_EN_O}, 64'h00);
    @(posedge TCK_I);
    // consumer stalls the whole time, so these fill the buffer until it refuses
    for (int i = 0; i < 40; i++) begin
      wr(1'b0, 8'(i));
    end
    chk({63'h0, CFG_VALID_O}, 64'h1);
    @(posedge CLK_I);
    CFG_READY_I <= 1'b1;
    repeat (400) @(posedge CLK_I);
    chk({63'h0, CFG_VALID_O}, 64'h0);
    chk({63'h0, n_rec >= 32}, 64'h1);
    chk({47'h0, last_rec}, {47'h0, 1'b0, 8'h07, 8'h27});
    end_sim();
  end
endmodule : tb
`default_nettype wire
